// *** inc/card_ctrl_consts.svh ***
// register map, field positions, reset values and timing counts of the card control block
// assumes inclusion by bare name from the core and the testbench
`ifndef CARD_CTRL_CONSTS_SVH
`define CARD_CTRL_CONSTS_SVH

`define REG_CFG_OPTION 8'h00
`define REG_CFG_STATUS 8'h04
`define REG_PIN_REPLACE 8'h08
`define REG_DEV_CONTROL 8'h0C
`define REG_ATA_STATUS 8'h10

`define CFG_IDX_MSB 5
`define CFG_PULSE_BIT 6
`define CFG_CARD_SOFT_RST_BIT 7
`define CFG_IDX_MEMORY 6'h00

`define CST_CHANGED_BIT 1
`define CST_PDOWN_BIT 2
`define CST_SIGCHG_BIT 6

`define PRR_READY_BIT 1
`define PRR_READY_CHG_BIT 5

`define DCR_IRQ_DIS_BIT 1
`define DCR_ATA_SOFT_RST_BIT 2

`define STAT_BUSY_BIT 7
`define STAT_DRDY_BIT 6

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RDATA_ZERO 32'h00000000

`define RESET_BUSY_CYCLES 64
`define PDOWN_BUSY_CYCLES 16
`define ATA_SOFT_RST_BUSY_CYCLES 8
`define IRQ_PULSE_CYCLES 4

`endif

// *** inc/card_ctrl_pkg.sv ***
// types shared by the card control block
// assumes the constants header is on the include path
package card_ctrl_pkg;
  typedef logic [7:0] reg_addr_t;
  typedef logic [31:0] reg_data_t;
  typedef logic [3:0] reg_strb_t;
  typedef logic [1:0] resp_t;
  typedef enum logic [1:0] {IRQ_IDLE, IRQ_PULSE, IRQ_WAIT} irq_state_t;
endpackage

// *** core/card_ctrl.sv ***
// card-side reset, busy/ready and interrupt request logic with an AXI4-Lite register slave
// assumes one clock mclk; the host reset pin is asynchronous and is synchronised here;
// the ATA engine beside this block drives engine_busy and ata_irq_event on mclk
//
// Functional notes
// - absent audio output pin is held high at all times.
// - memory mode second battery-detect pin stays high, no on-card battery.
// - status-change output exists because both config status and pin replacement exist.
// - status-change negated when unused; memory mode first battery-detect pin stays high.
// - memory-mapped addressing is supported, so address line ten must exist.
// - power-on, host reset, card soft reset clear config index, start hard reset.
// - card soft reset acts as host reset but its own bit stays set.
// - ATA soft reset bit runs soft reset, config left untouched.
// - pin shows ready in memory mode and the interrupt request in I/O mode.
// - ready pin negated while busy; host treats negated as busy.
// - pin replacement ready bit reads 0 while busy, 1 while ready.
// - busy from power-on, hardware reset and card soft reset until ready.
// - any change of the power-down bit makes the card busy until done.
// - in memory mode the card is busy whenever the ATA busy flag is set.
// - interrupt request driven only when configured for the I/O interface.
// - card interrupt request is active low, inverse of the ATA request.
// - level interrupt mode always, pulse mode optional for shared lines.
// - while interrupts are disabled the request is held negated, still driven.
// - configuration index zero selects memory-only interface, so reset means memory.
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "card_ctrl_consts.svh"

module card_ctrl #(
  parameter int RESET_BUSY_CYCLES = `RESET_BUSY_CYCLES,
  parameter int PDOWN_BUSY_CYCLES = `PDOWN_BUSY_CYCLES,
  parameter int SOFT_RST_BUSY_CYCLES = `ATA_SOFT_RST_BUSY_CYCLES,
  parameter int IRQ_PULSE_CYCLES = `IRQ_PULSE_CYCLES,
  parameter int CNT_W = 16,
  parameter bit MEM_MAP_SUPPORT = 1'b1,
  parameter bit ADDR_LINE_TEN_IMPL = 1'b1
) (
  // clock and power-on reset
  input wire logic mclk,
  input wire logic sys_rst,
  // card pins
  input wire logic host_reset,
  output logic ready_irq_pin,
  output logic audio_out_n,
  output logic status_change_n,
  // ATA engine
  input wire logic engine_busy,
  input wire logic ata_irq_event,
  // AXI4-Lite write
  input wire card_ctrl_pkg::reg_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire card_ctrl_pkg::reg_data_t s_axi_wdata,
  input wire card_ctrl_pkg::reg_strb_t s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output card_ctrl_pkg::resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire card_ctrl_pkg::reg_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output card_ctrl_pkg::reg_data_t s_axi_rdata,
  output card_ctrl_pkg::resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import card_ctrl_pkg::*;

  generate
    if (MEM_MAP_SUPPORT && !ADDR_LINE_TEN_IMPL) begin : g_addr_ten_check
      $error("memory-mapped addressing needs address line ten");
    end
    if (RESET_BUSY_CYCLES < 1 || RESET_BUSY_CYCLES >= (1 << CNT_W) ||
        PDOWN_BUSY_CYCLES < 1 || PDOWN_BUSY_CYCLES >= (1 << CNT_W) ||
        SOFT_RST_BUSY_CYCLES < 1 || SOFT_RST_BUSY_CYCLES >= (1 << CNT_W) ||
        IRQ_PULSE_CYCLES < 1 || IRQ_PULSE_CYCLES > 64) begin : g_cnt_check
      $error("busy or pulse count out of range");
    end
  endgenerate

  function automatic logic reg_hit(input reg_addr_t addr, input reg_addr_t off);
    reg_hit = (addr[7:2] == off[7:2]);
  endfunction

  logic host_rst_meta_ff;
  logic host_rst_sync_ff;
  logic aw_hold_ff;
  logic w_hold_ff;
  reg_addr_t aw_addr_ff;
  reg_data_t w_data_ff;
  reg_strb_t w_strb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  resp_t bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  reg_data_t rdata_ff;
  resp_t rresp_ff;
  logic [`CFG_IDX_MSB:0] cfg_index_ff;
  logic pulse_sel_ff;
  logic card_soft_rst_ff;
  logic pdown_ff;
  logic sigchg_en_ff;
  logic irq_dis_ff;
  logic ata_soft_rst_ff;
  logic [CNT_W-1:0] rst_cnt_ff;
  logic [CNT_W-1:0] pd_cnt_ff;
  logic [CNT_W-1:0] ata_cnt_ff;
  logic [CNT_W-1:0] pulse_cnt_ff;
  logic ready_mirror_ff;
  logic ready_chg_ff;
  logic irq_pend_ff;
  irq_state_t irq_st_ff;
  logic ready_irq_pin_ff;
  logic audio_out_n_ff;
  logic status_change_n_ff;

  logic hard_rst;
  logic wr_go;
  logic wr_ok;
  logic wr_cfg;
  logic wr_cst;
  logic wr_prr;
  logic wr_dcr;
  logic rd_go;
  logic rd_status;
  logic pd_change;
  logic mem_mode;
  logic busy_flag;
  logic card_busy;
  logic ata_irq;
  logic irq_line_n;

  // host reset pin synchroniser
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      host_rst_meta_ff <= 1'b0;
      host_rst_sync_ff <= 1'b0;
    end else begin
      host_rst_meta_ff <= host_reset;
      host_rst_sync_ff <= host_rst_meta_ff;
    end
  end

  assign hard_rst = sys_rst | host_rst_sync_ff | card_soft_rst_ff;
  assign mem_mode = (cfg_index_ff == `CFG_IDX_MEMORY);

  assign wr_go = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  assign wr_ok = wr_go & w_strb_ff[0];
  assign wr_cfg = wr_ok & reg_hit(aw_addr_ff, `REG_CFG_OPTION);
  assign wr_cst = wr_ok & reg_hit(aw_addr_ff, `REG_CFG_STATUS);
  assign wr_prr = wr_ok & reg_hit(aw_addr_ff, `REG_PIN_REPLACE);
  assign wr_dcr = wr_ok & reg_hit(aw_addr_ff, `REG_DEV_CONTROL);
  assign rd_go = s_axi_arvalid & arready_ff;
  assign rd_status = rd_go & reg_hit(s_axi_araddr, `REG_ATA_STATUS);

  // write channels taken in either order, response once both are held
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
        awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
        wready_ff <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (reg_hit(aw_addr_ff, `REG_CFG_OPTION) ||
                     reg_hit(aw_addr_ff, `REG_CFG_STATUS) ||
                     reg_hit(aw_addr_ff, `REG_PIN_REPLACE) ||
                     reg_hit(aw_addr_ff, `REG_DEV_CONTROL) ||
                     reg_hit(aw_addr_ff, `REG_ATA_STATUS)) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // read: answer one cycle after the address is taken
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= `RDATA_ZERO;
      rresp_ff <= `RESP_OKAY;
    end else if (rd_go) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= `RESP_OKAY;
      rdata_ff <= `RDATA_ZERO;
      if (reg_hit(s_axi_araddr, `REG_CFG_OPTION)) begin
        rdata_ff[`CFG_IDX_MSB:0] <= cfg_index_ff;
        rdata_ff[`CFG_PULSE_BIT] <= pulse_sel_ff;
        rdata_ff[`CFG_CARD_SOFT_RST_BIT] <= card_soft_rst_ff;
      end else if (reg_hit(s_axi_araddr, `REG_CFG_STATUS)) begin
        rdata_ff[`CST_CHANGED_BIT] <= ready_chg_ff;
        rdata_ff[`CST_PDOWN_BIT] <= pdown_ff;
        rdata_ff[`CST_SIGCHG_BIT] <= sigchg_en_ff;
      end else if (reg_hit(s_axi_araddr, `REG_PIN_REPLACE)) begin
        rdata_ff[`PRR_READY_BIT] <= ready_mirror_ff;
        rdata_ff[`PRR_READY_CHG_BIT] <= ready_chg_ff;
      end else if (reg_hit(s_axi_araddr, `REG_DEV_CONTROL)) begin
        rdata_ff[`DCR_IRQ_DIS_BIT] <= irq_dis_ff;
        rdata_ff[`DCR_ATA_SOFT_RST_BIT] <= ata_soft_rst_ff;
      end else if (rd_status) begin
        rdata_ff[`STAT_BUSY_BIT] <= busy_flag;
        rdata_ff[`STAT_DRDY_BIT] <= ~busy_flag;
      end else begin
        rresp_ff <= `RESP_SLVERR;
      end
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // config index cleared by every hard reset
  always_ff @(posedge mclk) begin
    if (hard_rst) begin
      cfg_index_ff <= `CFG_IDX_MEMORY;
      pulse_sel_ff <= 1'b0;
    end else if (wr_cfg) begin
      cfg_index_ff <= w_data_ff[`CFG_IDX_MSB:0];
      pulse_sel_ff <= w_data_ff[`CFG_PULSE_BIT];
    end
  end

  // soft reset bit survives its own reset
  always_ff @(posedge mclk) begin
    if (sys_rst || host_rst_sync_ff) begin
      card_soft_rst_ff <= 1'b0;
    end else if (wr_cfg) begin
      card_soft_rst_ff <= w_data_ff[`CFG_CARD_SOFT_RST_BIT];
    end
  end

  assign pd_change = wr_cst & (w_data_ff[`CST_PDOWN_BIT] != pdown_ff);

  always_ff @(posedge mclk) begin
    if (hard_rst) begin
      pdown_ff <= 1'b0;
      sigchg_en_ff <= 1'b0;
    end else if (wr_cst) begin
      pdown_ff <= w_data_ff[`CST_PDOWN_BIT];
      sigchg_en_ff <= w_data_ff[`CST_SIGCHG_BIT];
    end
  end

  // device control is ATA state, not bus configuration
  always_ff @(posedge mclk) begin
    if (hard_rst) begin
      irq_dis_ff <= 1'b0;
      ata_soft_rst_ff <= 1'b0;
    end else if (wr_dcr) begin
      irq_dis_ff <= w_data_ff[`DCR_IRQ_DIS_BIT];
      ata_soft_rst_ff <= w_data_ff[`DCR_ATA_SOFT_RST_BIT];
    end
  end

  // hard reset busy time, restarts while any source is held
  always_ff @(posedge mclk) begin
    if (hard_rst) begin
      rst_cnt_ff <= CNT_W'(RESET_BUSY_CYCLES);
    end else if (rst_cnt_ff != '0) begin
      rst_cnt_ff <= rst_cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (hard_rst) begin
      pd_cnt_ff <= '0;
    end else if (pd_change) begin
      pd_cnt_ff <= CNT_W'(PDOWN_BUSY_CYCLES);
    end else if (pd_cnt_ff != '0) begin
      pd_cnt_ff <= pd_cnt_ff - 1'b1;
    end
  end

  // ATA soft reset busy time, counted after the bit drops
  always_ff @(posedge mclk) begin
    if (hard_rst) begin
      ata_cnt_ff <= '0;
    end else if (ata_soft_rst_ff) begin
      ata_cnt_ff <= CNT_W'(SOFT_RST_BUSY_CYCLES);
    end else if (ata_cnt_ff != '0) begin
      ata_cnt_ff <= ata_cnt_ff - 1'b1;
    end
  end

  assign busy_flag = (rst_cnt_ff != '0) | (ata_cnt_ff != '0) | ata_soft_rst_ff | engine_busy;
  // reset busy, ATA busy only counts in memory mode
  assign card_busy = hard_rst | (rst_cnt_ff != '0) | (pd_cnt_ff != '0) | (mem_mode & busy_flag);

  // mirror and sticky change, set wins over clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ready_mirror_ff <= 1'b0;
      ready_chg_ff <= 1'b0;
    end else begin
      ready_mirror_ff <= ~card_busy;
      if (ready_mirror_ff == card_busy) begin
        ready_chg_ff <= 1'b1;
      end else if (host_rst_sync_ff || card_soft_rst_ff) begin
        ready_chg_ff <= 1'b0;
      end else if (wr_prr && w_data_ff[`PRR_READY_CHG_BIT]) begin
        ready_chg_ff <= 1'b0;
      end
    end
  end

  // pending until status read, a new event wins
  always_ff @(posedge mclk) begin
    if (hard_rst || ata_soft_rst_ff) begin
      irq_pend_ff <= 1'b0;
    end else if (ata_irq_event) begin
      irq_pend_ff <= 1'b1;
    end else if (rd_status) begin
      irq_pend_ff <= 1'b0;
    end
  end

  assign ata_irq = irq_pend_ff & ~irq_dis_ff;

  // pulse mode, one pulse per request, re-armed when it clears
  always_ff @(posedge mclk) begin
    if (hard_rst) begin
      irq_st_ff <= IRQ_IDLE;
      pulse_cnt_ff <= '0;
    end else begin
      case (irq_st_ff)
        IRQ_IDLE: begin
          if (ata_irq && pulse_sel_ff) begin
            irq_st_ff <= IRQ_PULSE;
            pulse_cnt_ff <= CNT_W'(IRQ_PULSE_CYCLES - 1);
          end
        end
        IRQ_PULSE: begin
          if (pulse_cnt_ff == '0) begin
            irq_st_ff <= IRQ_WAIT;
          end else begin
            pulse_cnt_ff <= pulse_cnt_ff - 1'b1;
          end
        end
        IRQ_WAIT: begin
          if (!ata_irq || !pulse_sel_ff) begin
            irq_st_ff <= IRQ_IDLE;
          end
        end
        default: begin
          irq_st_ff <= IRQ_IDLE;
        end
      endcase
    end
  end

  // active low; disable keeps it high, never released
  assign irq_line_n = irq_dis_ff | (pulse_sel_ff ? (irq_st_ff != IRQ_PULSE) : ~ata_irq);

  // pin state is registered so the pins never glitch on mode changes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ready_irq_pin_ff <= 1'b0;
      audio_out_n_ff <= 1'b1;
      status_change_n_ff <= 1'b1;
    end else begin
      // ready in memory mode; low while busy; request only in I/O mode
      ready_irq_pin_ff <= mem_mode ? ~card_busy : irq_line_n;
      // no audio, no battery, both read high
      audio_out_n_ff <= 1'b1;
      // status change from ready change; high in memory mode
      status_change_n_ff <= mem_mode | ~(sigchg_en_ff & ready_chg_ff);
    end
  end

  assign ready_irq_pin = ready_irq_pin_ff;
  assign audio_out_n = audio_out_n_ff;
  assign status_change_n = status_change_n_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  sequence s_pulse_start;
    irq_st_ff == IRQ_IDLE && ata_irq && pulse_sel_ff && !hard_rst;
  endsequence
  sequence s_pulse_done;
    ##[1:66] irq_st_ff == IRQ_WAIT;
  endsequence

  property p_audio_high;
    @(posedge mclk) disable iff (sys_rst) $past(sys_rst) == 1'b0 |-> audio_out_n_ff;
  endproperty
  a_audio_high: assert property (p_audio_high) else $error("audio pin not high");

  property p_mem_chg_high;
    @(posedge mclk) disable iff (sys_rst) $past(mem_mode) |-> status_change_n_ff;
  endproperty
  a_mem_chg_high: assert property (p_mem_chg_high) else $error("battery pin low");

  property p_reset_clears;
    @(posedge mclk) disable iff (sys_rst) (host_rst_sync_ff || card_soft_rst_ff) |=>
      cfg_index_ff == `CFG_IDX_MEMORY && rst_cnt_ff == RESET_BUSY_CYCLES && mem_mode;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset left config");

  property p_soft_bit_kept;
    @(posedge mclk) disable iff (sys_rst)
      card_soft_rst_ff && !host_rst_sync_ff && !wr_cfg |=> card_soft_rst_ff;
  endproperty
  a_soft_bit_kept: assert property (p_soft_bit_kept) else $error("soft bit lost");

  property p_ata_soft_rst;
    @(posedge mclk) disable iff (sys_rst) ata_soft_rst_ff && !hard_rst && !wr_cfg |=>
      $stable(cfg_index_ff) && ata_cnt_ff == SOFT_RST_BUSY_CYCLES && busy_flag;
  endproperty
  a_ata_soft_rst: assert property (p_ata_soft_rst) else $error("ATA soft reset wrong");

  property p_ready_pin;
    @(posedge mclk) disable iff (sys_rst)
      $past(mem_mode) && !$past(sys_rst) |-> ready_irq_pin_ff == !$past(card_busy);
  endproperty
  a_ready_pin: assert property (p_ready_pin) else $error("ready pin wrong");

  property p_mirror;
    @(posedge mclk) disable iff (sys_rst)
      !$past(sys_rst) |-> ready_mirror_ff == !$past(card_busy);
  endproperty
  a_mirror: assert property (p_mirror) else $error("ready mirror wrong");

  property p_reset_busy;
    @(posedge mclk) disable iff (sys_rst) $fell(hard_rst) |-> !ready_mirror_ff ##1 !ready_mirror_ff;
  endproperty
  a_reset_busy: assert property (p_reset_busy) else $error("ready during reset");

  property p_pd_busy;
    @(posedge mclk) disable iff (sys_rst)
      pd_change && !hard_rst |=> pd_cnt_ff == PDOWN_BUSY_CYCLES && card_busy;
  endproperty
  a_pd_busy: assert property (p_pd_busy) else $error("power-down not busy");

  property p_bsy_mem;
    @(posedge mclk) disable iff (sys_rst) mem_mode && busy_flag |-> card_busy;
  endproperty
  a_bsy_mem: assert property (p_bsy_mem) else $error("busy flag not reported");

  property p_level_irq;
    @(posedge mclk) disable iff (sys_rst) $past(!mem_mode && !pulse_sel_ff && ata_irq) &&
      !$past(hard_rst) |-> !ready_irq_pin_ff;
  endproperty
  a_level_irq: assert property (p_level_irq) else $error("level request not low");

  property p_pulse_ends;
    @(posedge mclk) disable iff (sys_rst) s_pulse_start |-> s_pulse_done or ##[1:66] hard_rst;
  endproperty
  a_pulse_ends: assert property (p_pulse_ends) else $error("pulse never ended");

  property p_irq_disabled;
    @(posedge mclk) disable iff (sys_rst)
      $past(!mem_mode && irq_dis_ff) && !$past(sys_rst) |-> ready_irq_pin_ff;
  endproperty
  a_irq_disabled: assert property (p_irq_disabled) else $error("request while disabled");

  property p_pend_hold;
    @(posedge mclk) disable iff (sys_rst)
      irq_pend_ff && !rd_status && !hard_rst && !ata_soft_rst_ff |=> irq_pend_ff;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending dropped early");
endmodule

// *** dv/card_host_model.sv ***
// host socket model: drives the card reset pin and reads the ready/irq pin
// assumes the card pin is sampled on mclk rising edges
`timescale 1ns/1ps
module card_host_model (
  // clock
  input wire logic mclk,
  // card side
  input wire logic ready_irq_pin,
  output logic host_reset,
  // host side
  output logic host_busy,
  output logic isa_irq
);
  event hw_reset_ev;
  // reset after power-on, then on request
  initial begin
    host_reset = 1'b1;
    repeat (4) @(posedge mclk);
    host_reset <= 1'b0;
    forever begin
      @(hw_reset_ev);
      @(posedge mclk);
      host_reset <= 1'b1;
      repeat (3) @(posedge mclk);
      host_reset <= 1'b0;
    end
  end
  // only the process above drives the pin; callers just request a pulse
  task automatic hw_reset();
    -> hw_reset_ev;
  endtask
  assign host_busy = !ready_irq_pin;
  assign isa_irq = ready_irq_pin;
endmodule

// *** dv/card_ctrl_tb_top.sv ***
// self-checking bench for the card control block
// assumes the host model file and the card control core are compiled before it
`timescale 1ns/1ps
`include "card_ctrl_consts.svh"
module card_ctrl_tb_top;
  import card_ctrl_pkg::*;
  localparam int PULSE = 2;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic engine_busy = 1'b0;
  logic ata_irq_event = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  // responses always accepted at once
  logic bready = 1'b1;
  logic rready = 1'b1;
  reg_strb_t wstrb = 4'hF;
  reg_addr_t awaddr = 8'h00;
  reg_addr_t araddr = 8'h00;
  reg_data_t wdata = 32'h00000000;
  logic host_reset, ready_irq_pin, audio_out_n, status_change_n, host_busy, isa_irq;
  logic awready, wready, bvalid, arready, rvalid;
  resp_t bresp, rresp;
  reg_data_t rdata;
  int failures = 0;
  int samples_checked = 0;

  always #10 mclk = ~mclk;

  card_ctrl #(.RESET_BUSY_CYCLES(4), .PDOWN_BUSY_CYCLES(4), .SOFT_RST_BUSY_CYCLES(2),
    .IRQ_PULSE_CYCLES(PULSE)) dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .host_reset(host_reset),
    .ready_irq_pin(ready_irq_pin), .audio_out_n(audio_out_n),
    .status_change_n(status_change_n), .engine_busy(engine_busy),
    .ata_irq_event(ata_irq_event), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  card_host_model host_u (.mclk(mclk), .ready_irq_pin(ready_irq_pin),
    .host_reset(host_reset), .host_busy(host_busy), .isa_irq(isa_irq));

  task automatic final_report();
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic tmo();
    failures++;
    $display("ERROR %0t wait ran out", $time);
    final_report();
  endtask

  task automatic chk(input reg_data_t got, input reg_data_t exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input reg_addr_t a, input reg_data_t d, input resp_t er = `RESP_OKAY);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    if (!bvalid) tmo();
    chk(bresp, er);
  endtask

  task automatic rd_chk(input reg_addr_t a, input reg_data_t m, input reg_data_t e,
      input resp_t er = `RESP_OKAY);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    if (!rvalid) tmo();
    chk(rdata & m, e);
    chk(rresp, er);
  endtask

  // polls the pin as sampled at each rising edge
  task automatic wait_pin(input logic v);
    int n;
    n = 0;
    while (ready_irq_pin !== v && n < 300) begin
      @(posedge mclk);
      n++;
    end
    if (ready_irq_pin !== v) tmo();
  endtask

  task automatic irq_event();
    ata_irq_event <= 1'b1;
    @(posedge mclk);
    ata_irq_event <= 1'b0;
  endtask

  task automatic s_power_on();
    chk(host_busy, 1'b1);
    rd_chk(`REG_PIN_REPLACE, 32'h2, 32'h0);
    wait_pin(1'b1);
    rd_chk(`REG_PIN_REPLACE, 32'h2, 32'h2);
    rd_chk(`REG_CFG_OPTION, 32'hFF, 32'h0);
    chk(audio_out_n, 1'b1);
    chk(status_change_n, 1'b1);
  endtask

  task automatic s_engine_busy();
    engine_busy <= 1'b1;
    wait_pin(1'b0);
    rd_chk(`REG_ATA_STATUS, 32'h80, 32'h80);
    engine_busy <= 1'b0;
    wait_pin(1'b1);
  endtask

  task automatic s_pdown();
    axi_wr(`REG_CFG_STATUS, 32'h04);
    wait_pin(1'b0);
    wait_pin(1'b1);
    axi_wr(`REG_CFG_STATUS, 32'h00);
    wait_pin(1'b0);
    wait_pin(1'b1);
  endtask

  task automatic s_irq_level();
    axi_wr(`REG_CFG_OPTION, 32'h01);
    wait_pin(1'b1);
    chk(audio_out_n, 1'b1);
    // busy must not reach the pin in this mode
    engine_busy <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(ready_irq_pin, 1'b1);
    engine_busy <= 1'b0;
    axi_wr(`REG_CFG_STATUS, 32'h40);
    repeat (4) @(posedge mclk);
    chk(status_change_n, 1'b0);
    axi_wr(`REG_PIN_REPLACE, 32'h20);
    repeat (4) @(posedge mclk);
    chk(status_change_n, 1'b1);
    axi_wr(`REG_CFG_STATUS, 32'h00);
    irq_event();
    wait_pin(1'b0);
    repeat (10) @(posedge mclk);
    chk(ready_irq_pin, 1'b0);
    axi_wr(`REG_DEV_CONTROL, 32'h02);
    wait_pin(1'b1);
    axi_wr(`REG_DEV_CONTROL, 32'h00);
    wait_pin(1'b0);
    rd_chk(`REG_ATA_STATUS, 32'h40, 32'h40);
    wait_pin(1'b1);
  endtask

  task automatic s_irq_pulse();
    int n;
    n = 0;
    axi_wr(`REG_CFG_OPTION, 32'h41);
    irq_event();
    wait_pin(1'b0);
    chk(isa_irq, 1'b0);
    do begin
      @(posedge mclk);
      n++;
    end while (ready_irq_pin === 1'b0 && n < 20);
    chk(n, PULSE);
    rd_chk(`REG_ATA_STATUS, 32'h40, 32'h40);
  endtask

  task automatic s_ata_soft();
    axi_wr(`REG_DEV_CONTROL, 32'h04);
    rd_chk(`REG_ATA_STATUS, 32'h80, 32'h80);
    axi_wr(`REG_DEV_CONTROL, 32'h00);
    rd_chk(`REG_CFG_OPTION, 32'hFF, 32'h41);
  endtask

  task automatic s_card_soft();
    axi_wr(`REG_CFG_OPTION, 32'h81);
    rd_chk(`REG_CFG_OPTION, 32'hFF, 32'h80);
    wait_pin(1'b0);
    axi_wr(`REG_CFG_OPTION, 32'h00);
    wait_pin(1'b1);
  endtask

  task automatic s_hw_reset();
    axi_wr(`REG_CFG_OPTION, 32'h01);
    host_u.hw_reset();
    wait_pin(1'b0);
    rd_chk(`REG_CFG_OPTION, 32'hFF, 32'h00);
    wait_pin(1'b1);
    rd_chk(8'h40, 32'hFFFFFFFF, `RDATA_ZERO, `RESP_SLVERR);
    axi_wr(8'h40, 32'h0000005A, `RESP_SLVERR);
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    s_power_on();
    s_engine_busy();
    s_pdown();
    s_irq_level();
    s_irq_pulse();
    s_ata_soft();
    s_card_soft();
    s_hw_reset();
    final_report();
  end
endmodule
